// file: verilog/pmr_pkg.sv
/*
 * Shared constants and types of the PCS managed register block: register
 * numbers, bit positions, reset values, frame fields and decoder states.
 * Assumes clause 22 style management frames on the serial management pins.
 */
`default_nettype none

package pmr_pkg;

    // ----------------------------------------------------------------
    // Register numbers
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_PCS_CONTROL = 5'h00;
    localparam logic [4:0] REG_PCS_STATUS = 5'h01;
    localparam logic [4:0] REG_PHY_ID_HI = 5'h02;
    localparam logic [4:0] REG_PHY_ID_LO = 5'h03;
    localparam logic [4:0] REG_AN_ADVERT = 5'h04;
    localparam logic [4:0] REG_AN_PARTNER = 5'h05;
    localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
    localparam logic [4:0] REG_AN_NP_TX = 5'h07;
    localparam logic [4:0] REG_AN_NP_RX = 5'h08;
    localparam logic [4:0] REG_EXT_STATUS = 5'h0F;

    // ----------------------------------------------------------------
    // Control register bit positions
    // ----------------------------------------------------------------
    localparam int CTL_RESET_BIT = 15;
    localparam int CTL_LOOPBACK_BIT = 14;
    localparam int CTL_SPEED_LSB_BIT = 13;
    localparam int CTL_AN_ENABLE_BIT = 12;
    localparam int CTL_POWER_DOWN_BIT = 11;
    localparam int CTL_ISOLATE_BIT = 10;
    localparam int CTL_AN_RESTART_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam int CTL_COL_TEST_BIT = 7;
    localparam int CTL_SPEED_MSB_BIT = 6;

    // ----------------------------------------------------------------
    // Status register bit positions and fixed upper field
    // ----------------------------------------------------------------
    localparam logic [6:0] STS_ABILITY_NONE = 7'h00;
    localparam int STS_EXT_STATUS_BIT = 8;
    localparam int STS_PRE_SUPPRESS_BIT = 6;
    localparam int STS_AN_COMPLETE_BIT = 5;
    localparam int STS_REMOTE_FAULT_BIT = 4;
    localparam int STS_AN_ABILITY_BIT = 3;
    localparam int STS_LINK_BIT = 2;

    // ----------------------------------------------------------------
    // Other fixed and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;
    localparam logic [15:0] AN_EXPANSION_FIXED = 16'h0004;
    localparam logic [15:0] AN_ADVERT_RESET = 16'h01A0;
    localparam logic [15:0] AN_ADVERT_WMASK = 16'hB1A0;
    localparam logic [15:0] AN_NP_TX_RESET = 16'h2001;
    localparam logic [15:0] AN_NP_TX_WMASK = 16'hB7FF;

    // ----------------------------------------------------------------
    // Frame fields
    // ----------------------------------------------------------------
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [3:0] HDR_BITS = 4'hC;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [5:0] PRE_MIN = 6'h01;
    localparam logic [5:0] PRE_SAT = 6'h3F;

    typedef enum logic [2:0] {
        ST_PRE = 3'b000,
        ST_START = 3'b001,
        ST_HDR = 3'b010,
        ST_TA = 3'b011,
        ST_RD = 3'b100,
        ST_WR = 3'b101
    } pmr_state_e;

    // Writable control fields that steer the sublayer
    typedef struct packed {
        logic loopback;
        logic an_enable;
        logic power_down;
        logic isolate;
    } pmr_ctrl_s;

    localparam pmr_ctrl_s CTRL_RESET = '{
        loopback: 1'b0, an_enable: 1'b1, power_down: 1'b0, isolate: 1'b1};

endpackage : pmr_pkg

`default_nettype wire

// file: verilog/pmr_regs.sv
/*
 * PCS managed register block reached as a PHY over the serial management
 * pins. Holds the control, status and auto-negotiation page registers.
 * Assumes the management clock and data pins are asynchronous to i_clk_sys
 * and slow against it; status inputs come from logic on i_clk_sys.
 */
// Overview of operation
// - Registers answer serial management reads and writes exactly like an external PHY.
// - Ten management registers configure and monitor PCS, PMA and auto-negotiation.
// - Power down bit sets low power; only the self-clearing reset bit leaves it.
// - Loopback bit is read/write, default 0, enables loopback when 1.
// - Auto-negotiation enable bit is read/write, default 1.
// - Isolate bit is read/write, default 1; isolates from GMII while set.
// - Restart bit starts auto-negotiation again, clears itself, default 0.
// - Speed bits fixed: LSB reads 0, MSB reads 1, meaning 1000 Mb/s.
// - Duplex bit always reads 1; writes to it do nothing.
// - Collision test bit always reads 0.
// - Low six control bits reserved: read zero, writes discarded.
// - Status ability bits 15 to 9 always read 0.
// - Status bit 8 always reads 1: extended status present.
// - All logic runs on one shared fast user clock, also given to the client.
// - Status bit 5 reads 1 once auto-negotiation completed.
// - Status bit 4 latches a remote fault and clears when read.
`timescale 1ns/100ps
`default_nettype none

module pmr_regs (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_mdc,
    input wire logic i_mdio_in,
    input wire logic [4:0] i_phy_addr,
    input wire logic i_an_complete,
    input wire logic i_remote_fault,
    input wire logic i_link_up,
    input wire logic [15:0] i_partner_ability,
    input wire logic i_page_received,
    input wire logic [15:0] i_np_rx,
    output logic o_mdio_out,
    output logic o_mdio_oe,
    output pmr_pkg::pmr_ctrl_s o_ctrl,
    output logic o_pcs_reset,
    output logic o_an_restart
);
    import pmr_pkg::*;

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    function automatic logic [15:0] read_word(
        input logic [4:0] addr,
        input pmr_ctrl_s ctrl,
        input logic an_done,
        input logic rfault,
        input logic link,
        input logic [15:0] advert,
        input logic [15:0] partner,
        input logic page_rx,
        input logic [15:0] np_tx,
        input logic [15:0] np_rx
    );
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            REG_PCS_CONTROL: begin
                w[CTL_LOOPBACK_BIT] = ctrl.loopback;
                w[CTL_SPEED_LSB_BIT] = 1'b0;
                w[CTL_SPEED_MSB_BIT] = 1'b1;
                w[CTL_AN_ENABLE_BIT] = ctrl.an_enable;
                w[CTL_POWER_DOWN_BIT] = ctrl.power_down;
                w[CTL_ISOLATE_BIT] = ctrl.isolate;
                w[CTL_DUPLEX_BIT] = 1'b1;
                w[CTL_COL_TEST_BIT] = 1'b0;
                w[CTL_RESET_BIT] = 1'b0;
                w[CTL_AN_RESTART_BIT] = 1'b0;
            end
            REG_PCS_STATUS: begin
                w[15:9] = STS_ABILITY_NONE;
                w[STS_EXT_STATUS_BIT] = 1'b1;
                w[STS_PRE_SUPPRESS_BIT] = 1'b1;
                w[STS_AN_COMPLETE_BIT] = an_done;
                w[STS_REMOTE_FAULT_BIT] = rfault;
                w[STS_AN_ABILITY_BIT] = 1'b1;
                w[STS_LINK_BIT] = link;
            end
            REG_AN_ADVERT: w = advert;
            REG_AN_PARTNER: w = partner;
            REG_AN_EXPANSION: w = AN_EXPANSION_FIXED | {14'h0000, page_rx, 1'b0};
            REG_AN_NP_TX: w = np_tx;
            REG_AN_NP_RX: w = np_rx;
            REG_EXT_STATUS: w = EXT_STATUS_VALUE;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    // ----------------------------------------------------------------
    // Pin synchronisers and edge finder
    // ----------------------------------------------------------------
    logic mdc_s1_ff, mdc_s2_ff, mdc_s3_ff;
    logic mdio_s1_ff, mdio_s2_ff;
    logic mdc_rise;

    // Two flops per pin; the third MDC flop only feeds the edge finder
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mdc_s1_ff <= 1'b0;
            mdc_s2_ff <= 1'b0;
            mdc_s3_ff <= 1'b0;
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
        end else begin
            mdc_s1_ff <= i_mdc;
            mdc_s2_ff <= mdc_s1_ff;
            mdc_s3_ff <= mdc_s2_ff;
            mdio_s1_ff <= i_mdio_in;
            mdio_s2_ff <= mdio_s1_ff;
        end
    end

    assign mdc_rise = mdc_s2_ff & ~mdc_s3_ff;

    // ----------------------------------------------------------------
    // Frame decoder and register state
    // ----------------------------------------------------------------
    pmr_state_e state_ff, nxt_state;
    logic [5:0] pre_cnt_ff, nxt_pre_cnt;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [11:0] hdr_ff, nxt_hdr;
    logic [15:0] shift_ff, nxt_shift;
    logic ta_second_ff, nxt_ta_second;
    logic mdio_out_ff, nxt_mdio_out;
    logic mdio_oe_ff, nxt_mdio_oe;
    pmr_ctrl_s ctrl_ff, nxt_ctrl;
    logic pcs_reset_ff, nxt_pcs_reset;
    logic an_restart_ff, nxt_an_restart;
    logic rfault_ff, nxt_rfault;
    logic link_ff, nxt_link;
    logic page_rx_ff, nxt_page_rx;
    logic [15:0] advert_ff, nxt_advert;
    logic [15:0] np_tx_ff, nxt_np_tx;
    logic hit;
    logic [15:0] wdata;

    // Header is op(2) phy(5) reg(5); only our own address is answered
    assign hit = (hdr_ff[9:5] == i_phy_addr);
    assign wdata = {shift_ff[14:0], mdio_s2_ff};

    // Next-state logic: one step per rising management clock edge
    always_comb begin
        nxt_state = state_ff;
        nxt_pre_cnt = pre_cnt_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_hdr = hdr_ff;
        nxt_shift = shift_ff;
        nxt_ta_second = ta_second_ff;
        nxt_mdio_out = mdio_out_ff;
        nxt_mdio_oe = mdio_oe_ff;
        nxt_ctrl = ctrl_ff;
        nxt_pcs_reset = 1'b0;
        nxt_an_restart = 1'b0;
        // set wins over the clear on read
        nxt_rfault = rfault_ff | i_remote_fault;
        // Link is latched low until read, as a PHY reports it
        nxt_link = link_ff & i_link_up;
        nxt_page_rx = page_rx_ff | i_page_received;
        nxt_advert = advert_ff;
        nxt_np_tx = np_tx_ff;
        if (mdc_rise) begin
            case (state_ff)
                ST_PRE: begin
                    // Preamble may be cut short, so one idle one is enough
                    if (mdio_s2_ff) begin
                        if (pre_cnt_ff != PRE_SAT) begin
                            nxt_pre_cnt = pre_cnt_ff + 6'h01;
                        end
                    end else if (pre_cnt_ff >= PRE_MIN) begin
                        nxt_state = ST_START;
                    end
                end
                ST_START: begin
                    nxt_pre_cnt = 6'h00;
                    nxt_bit_cnt = 4'h0;
                    nxt_state = mdio_s2_ff ? ST_HDR : ST_PRE;
                end
                ST_HDR: begin
                    nxt_hdr = {hdr_ff[10:0], mdio_s2_ff};
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == HDR_BITS - 4'h1) begin
                        nxt_state = ST_TA;
                        nxt_ta_second = 1'b0;
                    end
                end
                ST_TA: begin
                    nxt_ta_second = 1'b1;
                    nxt_bit_cnt = 4'h0;
                    if (!hit || (hdr_ff[11:10] != OP_READ && hdr_ff[11:10] != OP_WRITE)) begin
                        nxt_state = ST_PRE;
                    end else if (hdr_ff[11:10] == OP_READ && !ta_second_ff) begin
                        nxt_mdio_oe = 1'b1;
                        nxt_mdio_out = 1'b0;
                        nxt_shift = read_word(hdr_ff[4:0], ctrl_ff, i_an_complete,
                            rfault_ff, link_ff, advert_ff, i_partner_ability,
                            page_rx_ff, np_tx_ff, i_np_rx);
                        if (hdr_ff[4:0] == REG_PCS_STATUS) begin
                            // clear on read, new event still kept
                            nxt_rfault = i_remote_fault;
                            nxt_link = i_link_up;
                        end
                        if (hdr_ff[4:0] == REG_AN_EXPANSION) begin
                            nxt_page_rx = i_page_received;
                        end
                    end else if (ta_second_ff) begin
                        nxt_state = (hdr_ff[11:10] == OP_READ) ? ST_RD : ST_WR;
                        if (hdr_ff[11:10] == OP_READ) begin
                            nxt_mdio_out = shift_ff[15];
                            nxt_shift = {shift_ff[14:0], 1'b0};
                        end
                    end
                end
                ST_RD: begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    nxt_mdio_out = shift_ff[15];
                    nxt_shift = {shift_ff[14:0], 1'b0};
                    // bit 0 stands a full period, released at the following rise
                    if (bit_cnt_ff == DATA_LAST) begin
                        nxt_mdio_oe = 1'b0;
                        nxt_mdio_out = 1'b0;
                        nxt_state = ST_PRE;
                    end
                end
                ST_WR: begin
                    nxt_shift = wdata;
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == DATA_LAST) begin
                        nxt_state = ST_PRE;
                        if (hdr_ff[4:0] == REG_PCS_CONTROL) begin
                            nxt_ctrl.loopback = wdata[CTL_LOOPBACK_BIT];
                            nxt_ctrl.an_enable = wdata[CTL_AN_ENABLE_BIT];
                            nxt_ctrl.isolate = wdata[CTL_ISOLATE_BIT];
                            nxt_ctrl.power_down = ctrl_ff.power_down
                                | wdata[CTL_POWER_DOWN_BIT];
                            nxt_an_restart = wdata[CTL_AN_RESTART_BIT];
                            if (wdata[CTL_RESET_BIT]) begin
                                // reset leaves power down, back to defaults
                                nxt_ctrl = CTRL_RESET;
                                nxt_advert = AN_ADVERT_RESET;
                                nxt_np_tx = AN_NP_TX_RESET;
                                // one pulse, the bit reads 0 afterwards
                                nxt_pcs_reset = 1'b1;
                                nxt_an_restart = 1'b0;
                            end
                        end else if (hdr_ff[4:0] == REG_AN_ADVERT) begin
                            nxt_advert = wdata & AN_ADVERT_WMASK;
                        end else if (hdr_ff[4:0] == REG_AN_NP_TX) begin
                            nxt_np_tx = wdata & AN_NP_TX_WMASK;
                        end
                    end
                end
                default: nxt_state = ST_PRE;
            endcase
        end
    end

    // everything sits on the one fast clock
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= ST_PRE;
            pre_cnt_ff <= 6'h00;
            bit_cnt_ff <= 4'h0;
            hdr_ff <= 12'h000;
            shift_ff <= 16'h0000;
            ta_second_ff <= 1'b0;
            mdio_out_ff <= 1'b0;
            mdio_oe_ff <= 1'b0;
            ctrl_ff <= CTRL_RESET;
            pcs_reset_ff <= 1'b0;
            an_restart_ff <= 1'b0;
            rfault_ff <= 1'b0;
            link_ff <= 1'b0;
            page_rx_ff <= 1'b0;
            advert_ff <= AN_ADVERT_RESET;
            np_tx_ff <= AN_NP_TX_RESET;
        end else begin
            state_ff <= nxt_state;
            pre_cnt_ff <= nxt_pre_cnt;
            bit_cnt_ff <= nxt_bit_cnt;
            hdr_ff <= nxt_hdr;
            shift_ff <= nxt_shift;
            ta_second_ff <= nxt_ta_second;
            mdio_out_ff <= nxt_mdio_out;
            mdio_oe_ff <= nxt_mdio_oe;
            ctrl_ff <= nxt_ctrl;
            pcs_reset_ff <= nxt_pcs_reset;
            an_restart_ff <= nxt_an_restart;
            rfault_ff <= nxt_rfault;
            link_ff <= nxt_link;
            page_rx_ff <= nxt_page_rx;
            advert_ff <= nxt_advert;
            np_tx_ff <= nxt_np_tx;
        end
    end

    // Outputs straight from flops
    assign o_mdio_out = mdio_out_ff;
    assign o_mdio_oe = mdio_oe_ff;
    assign o_ctrl = ctrl_ff;
    assign o_pcs_reset = pcs_reset_ff;
    assign o_an_restart = an_restart_ff;

endmodule : pmr_regs

`default_nettype wire

// file: test/pmr_regs_asserts.sv
/* Port checks of the managed register block.
   Assumes a bind onto pmr_regs; MDC is slow against i_clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_asserts
    import pmr_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_mdc,
    input wire logic o_mdio_out,
    input wire logic o_mdio_oe,
    input wire pmr_pkg::pmr_ctrl_s o_ctrl,
    input wire logic o_pcs_reset,
    input wire logic o_an_restart
);
    // ------------------------------------------------------------
    // Helper timing of the raw MDC pin
    // ------------------------------------------------------------
    logic mdc_ff, nxt_mdc, mdc_rise;
    logic [3:0] since_ff, nxt_since;
    logic [4:0] drive_ff, nxt_drive;

    // Raw edge leads the design's synchroniser, so bounds carry slack
    always_comb begin
        mdc_rise = i_mdc & ~mdc_ff;
        nxt_mdc = i_mdc;
        nxt_since = mdc_rise ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
        nxt_drive = !o_mdio_oe ? 5'h00 : drive_ff + {4'h0, mdc_rise};
    end

    // since_ff saturates so a quiet pin never wraps to a small value
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mdc_ff <= 1'b0;
            since_ff <= 4'hF;
            drive_ff <= 5'h00;
        end else begin
            mdc_ff <= nxt_mdc;
            since_ff <= nxt_since;
            drive_ff <= nxt_drive;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_launch;
        o_pcs_reset || o_an_restart;
    endsequence

    sequence s_defaults_back;
        ##[0:2] (o_ctrl == CTRL_RESET);
    endsequence

    a_rst_defaults: assert property (
        $fell(i_rst) |-> o_ctrl == CTRL_RESET && !o_mdio_oe) else $error("bad reset values");
    a_soft_reset: assert property (
        o_pcs_reset |-> s_defaults_back) else $error("soft reset kept control bits");
    a_pdown_hold: assert property (
        $fell(o_ctrl.power_down) |-> o_pcs_reset || $past(o_pcs_reset) || $past(o_pcs_reset, 2))
        else $error("power down left without reset");
    a_pulse_single: assert property (
        s_launch |=> !o_pcs_reset && !o_an_restart) else $error("pulse longer than one cycle");
    a_reset_wins: assert property (
        o_an_restart |-> !o_pcs_reset) else $error("restart together with reset");
    a_launch_timing: assert property (
        s_launch |-> since_ff <= 4'd7) else $error("pulse not after an MDC rise");
    a_ctrl_timing: assert property (
        $changed(o_ctrl) |-> since_ff <= 4'd9) else $error("control changed off frame end");
    a_ta_zero: assert property (
        $rose(o_mdio_oe) |-> !o_mdio_out && since_ff <= 4'd6) else $error("bad turnaround");
    a_bit_stands: assert property (
        o_mdio_oe && $past(o_mdio_oe) && $changed(o_mdio_out) |-> since_ff <= 4'd6)
        else $error("read bit changed mid period");
    a_drive_span: assert property (
        $fell(o_mdio_oe) |-> drive_ff == 5'd17) else $error("drive span not 17 periods");
endmodule : pmr_regs_asserts

bind pmr_regs pmr_regs_asserts i_pmr_regs_asserts (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_mdc(i_mdc), .o_mdio_out(o_mdio_out), .o_mdio_oe(o_mdio_oe), .o_ctrl(o_ctrl),
    .o_pcs_reset(o_pcs_reset), .o_an_restart(o_an_restart));
`default_nettype wire

// file: test/pmr_mdio_host.sv
/* Station manager model sending management frames to the block.
   Assumes a pull-up on the data pin and an MDC that idles low. */
`timescale 1ns/100ps
`default_nettype none
module pmr_mdio_host
    import pmr_pkg::*;
(
    input wire logic i_mdio_out,
    input wire logic i_mdio_oe,
    output logic o_mdc,
    output logic o_mdio_in
);
    // ------------------------------------------------------------
    // Pin state
    // ------------------------------------------------------------
    logic host_oe = 1'b0;
    logic host_bit = 1'b1;
    initial o_mdc = 1'b0;

    // Pull-up wins when nobody drives, so stale data never lingers
    assign o_mdio_in = i_mdio_oe ? i_mdio_out : (host_oe ? host_bit : 1'b1);

    // One 48 ns MDC period; data is set up half a period before the rise
    task automatic tick(input logic drv, input logic b, output logic smp);
        host_oe = drv;
        host_bit = b;
        #24;
        smp = o_mdio_in;
        o_mdc = 1'b1;
        #24;
        o_mdc = 1'b0;
    endtask : tick

    // frame as to an external PHY
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        logic s;
        bits = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
        // Callers start on a half-ns phase; shift so pin changes never meet a clock rise
        #0.5;
        for (int i = 63; i >= 0; i--) begin
            tick(op == OP_WRITE || i > 17, bits[i], s);
            rd = {rd[14:0], s};
        end
        host_oe = 1'b0;
        #99.5;
    endtask : frame
endmodule : pmr_mdio_host
`default_nettype wire

// file: test/pmr_regs_tb_top.sv
/* Self-checking bench of the managed register block.
   Assumes the host model is the only master of the management pins. */
`timescale 1ns/100ps
`default_nettype none
module pmr_regs_tb_top;
    import pmr_pkg::*;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [15:0] PARTNER = 16'h41A0;
    localparam logic [15:0] NP_RX = 16'h2801;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic mdc, mdio_w, mdio_out, mdio_oe, pcs_reset, an_restart;
    logic an_complete = 1'b0;
    logic remote_fault = 1'b0;
    logic link_up = 1'b0;
    pmr_ctrl_s ctrl;
    logic [15:0] d;
    logic [4:0] regs [9] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0F};
    logic [15:0] exps [9] = '{16'h0000, 16'h0000, 16'h01A0, PARTNER, 16'h0004, 16'h2001,
                             NP_RX, 16'h0000, 16'h8000};
    int err_total = 0;
    int samples_checked = 0;
    int n_reset = 0;
    int n_restart = 0;

    // ------------------------------------------------------------
    // Clock, instances and pulse counters
    // ------------------------------------------------------------
    // one bench source drives the one shared user clock
    always #2.5 i_clk_sys = ~i_clk_sys;

    pmr_regs i_pmr_regs (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mdc(mdc),
        .i_mdio_in(mdio_w), .i_phy_addr(PHY), .i_an_complete(an_complete),
        .i_remote_fault(remote_fault), .i_link_up(link_up), .i_partner_ability(PARTNER),
        .i_page_received(1'b0), .i_np_rx(NP_RX), .o_mdio_out(mdio_out),
        .o_mdio_oe(mdio_oe), .o_ctrl(ctrl), .o_pcs_reset(pcs_reset),
        .o_an_restart(an_restart));
    pmr_mdio_host i_pmr_mdio_host (.i_mdio_out(mdio_out), .i_mdio_oe(mdio_oe), .o_mdc(mdc),
        .o_mdio_in(mdio_w));

    // Pulses last one cycle, so they are counted rather than polled
    always @(posedge i_clk_sys) begin
        n_reset += int'(pcs_reset === 1'b1);
        n_restart += int'(an_restart === 1'b1);
    end

    // ------------------------------------------------------------
    // Access and comparison tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
        logic [15:0] v;
        i_pmr_mdio_host.frame(OP_READ, phy, rg, 16'h0000, v);
        check(v, exp, "register read");
    endtask : rd_chk

    task automatic wr(input logic [15:0] wd);
        i_pmr_mdio_host.frame(OP_WRITE, PHY, REG_PCS_CONTROL, wd, d);
    endtask : wr

    task automatic final_report;
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Generous against the roughly 70 us the frames take
    initial begin
        #300000;
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        check({12'h000, ctrl}, {12'h000, CTRL_RESET}, "control defaults");
        rd_chk(PHY, REG_PCS_CONTROL, 16'h1540);
        @(posedge i_clk_sys);
        #1;
        an_complete = 1'b1;
        link_up = 1'b1;
        remote_fault = 1'b1;
        @(posedge i_clk_sys);
        #1;
        remote_fault = 1'b0;
        rd_chk(PHY, REG_PCS_STATUS, 16'h0178);
        rd_chk(PHY, REG_PCS_STATUS, 16'h016C);
        @(posedge i_clk_sys);
        #1;
        an_complete = 1'b0;
        rd_chk(PHY, REG_PCS_STATUS, 16'h014C);
        wr(16'h6DFF);
        rd_chk(PHY, REG_PCS_CONTROL, 16'h4D40);
        check({12'h000, ctrl}, 16'h000B, "control after write");
        wr(16'h0000);
        rd_chk(PHY, REG_PCS_CONTROL, 16'h0940);
        wr(16'h0200);
        check(16'(n_restart), 16'h0001, "restart pulses");
        rd_chk(PHY, REG_PCS_CONTROL, 16'h0940);
        wr(16'h8200);
        check(16'(n_reset), 16'h0001, "reset pulses");
        check(16'(n_restart), 16'h0001, "restart with reset");
        rd_chk(PHY, REG_PCS_CONTROL, 16'h1540);
        rd_chk(PHY ^ 5'h01, REG_PCS_CONTROL, 16'hFFFF);
        i_pmr_mdio_host.frame(2'h3, PHY, REG_PCS_CONTROL, 16'h0000, d);
        check(d, 16'hFFFF, "reserved opcode ignored");
        for (int i = 0; i < 9; i++) begin
            rd_chk(PHY, regs[i], exps[i]);
        end
        final_report();
    end
endmodule : pmr_regs_tb_top
`default_nettype wire
